// ---- rtl/cal_ctrl_pkg.sv ----
// constants for the calibration control block
package cal_ctrl_pkg;
  // printed offsets are not all multiples of four: these are indices, byte address = 4 * index
  localparam logic [9:0] IDX_CAL_ENABLE = 10'h061;
  localparam logic [9:0] IDX_MODE_CONFIG = 10'h062;
  localparam logic [9:0] IDX_STATUS = 10'h06a;
  localparam logic [9:0] IDX_PIN_CONFIG = 10'h06b;
  localparam logic [9:0] IDX_SOFT_TRIG = 10'h06c;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h070;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h071;
  localparam int ADDR_LSB = 2;
  // mode config fields
  localparam int BIT_FG_SELECT = 0;
  localparam int BIT_BG_ENABLE = 1;
  localparam int BIT_FG_OFFSET = 2;
  localparam int BIT_BG_OFFSET = 3;
  localparam int BIT_OFS_FILTER = 4;
  // status fields
  localparam int BIT_FG_COMPLETE = 0;
  localparam int BIT_BG_STOPPED = 1;
  // pin config fields
  localparam int BIT_TRIG_SOURCE = 0;
  localparam int BIT_STAT_SEL_LO = 1;
  localparam logic [1:0] SEL_FG_COMPLETE = 2'h0;
  localparam logic [1:0] SEL_ALARM = 2'h2;
  localparam logic [1:0] SEL_LOW = 2'h3;
  // reset values
  localparam logic [7:0] RST_CAL_ENABLE = 8'h01;
  localparam logic [7:0] RST_MODE_CONFIG = 8'h01;
  localparam logic [7:0] RST_PIN_CONFIG = 8'h00;
  localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
  // irq events: 0 foreground complete, 1 background stopped
  localparam int IRQ_BITS = 2;
  // timing of the modelled calibration steps
  localparam int CLK_NS = 10;
  localparam int CLEAR_NS = 80;
  localparam int FG_CAL_NS = 640;
  localparam int CLEAR_CYC = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
  localparam int FG_CAL_CYC = (FG_CAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CLEAR = 3'b001,
    ST_FG = 3'b011,
    ST_BG = 3'b010,
    ST_STOPPED = 3'b110
  } cal_state_e;
endpackage

// ---- rtl/cal_sync2.sv ----
// two flip-flop synchroniser for a pin input
`timescale 1ns/10ps
module cal_sync2 (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic din,
  output logic dout
);
  logic stage1Reg;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage1Reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      stage1Reg <= din;
      dout <= stage1Reg;
    end
  end
endmodule // cal_sync2

// ---- rtl/adc_calibration_control.sv ----
// calibration control, status, trigger routing and status pin, APB slave
// Notes on behaviour
// RQ1: offset filter active only when bit 4 set
// RQ2: background offset needs background enable too
// RQ3: foreground offset needs foreground select too
// RQ4: background calibration runs only when bit 1 set
// RQ5: bit 0 high: clear values, then foreground
// RQ6: bit 0 low: clear values, skip foreground
// RQ7: stopped bit high when halted, low on resume
// RQ8: no background: stopped set after foreground done/skipped
// RQ9: foreground complete bit set when foreground finishes
// RQ10: status pin selector: done, alarm, or low
// RQ11: source bit 0: software trigger, pin ignored
// RQ12: source bit 1: trigger pin, software bit ignored
// RQ13: software trigger bit resets high
// RQ14: change mode config only while enable low
// RQ15: enable high runs calibration, low holds reset
// RQ16: reserved status bits read zero
`timescale 1ns/10ps
module adc_calibration_control (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic externalTriggerInput,
  input wire logic alarmFlag,
  output logic statusOutputPin,
  output logic offsetFilterActive,
  output logic foregroundOffsetActive,
  output logic backgroundOffsetActive,
  output logic clearCalValues,
  output logic calTrigger,
  output logic irq
);
  logic [7:0] calEnable_reg;
  logic [7:0] modeConfig_reg;
  logic [7:0] pinConfig_reg;
  logic [7:0] softTrig_reg;
  logic [1:0] irqStatus_reg;
  logic [1:0] irqMask_reg;
  logic fgComplete_reg;
  logic bgStopped_reg;
  logic [7:0] cnt_reg;
  logic statusPin_reg;
  logic trigSync;
  logic alarmSync;
  logic [9:0] index;
  logic wrEn;
  logic [1:0] irqEvent;
  logic calRun;
  cal_ctrl_pkg::cal_state_e state_reg;

  cal_sync2 u_trig_sync (.clk_sys(clk_sys), .resetn(resetn), .din(externalTriggerInput), .dout(trigSync));
  cal_sync2 u_alarm_sync (.clk_sys(clk_sys), .resetn(resetn), .din(alarmFlag), .dout(alarmSync));

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign index = paddr[11:cal_ctrl_pkg::ADDR_LSB];
  assign wrEn = psel && penable && pwrite;
  assign pslverr = psel && penable && !(index == cal_ctrl_pkg::IDX_CAL_ENABLE ||
    index == cal_ctrl_pkg::IDX_MODE_CONFIG || index == cal_ctrl_pkg::IDX_STATUS ||
    index == cal_ctrl_pkg::IDX_PIN_CONFIG || index == cal_ctrl_pkg::IDX_SOFT_TRIG ||
    index == cal_ctrl_pkg::IDX_IRQ_STATUS || index == cal_ctrl_pkg::IDX_IRQ_MASK);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      calEnable_reg <= cal_ctrl_pkg::RST_CAL_ENABLE;
      modeConfig_reg <= cal_ctrl_pkg::RST_MODE_CONFIG;
      pinConfig_reg <= cal_ctrl_pkg::RST_PIN_CONFIG;
      softTrig_reg <= cal_ctrl_pkg::RST_SOFT_TRIG; // RQ13
      irqMask_reg <= 2'h0;
    end else if (wrEn) begin
      if (index == cal_ctrl_pkg::IDX_CAL_ENABLE) calEnable_reg <= pwdata[7:0];
      // writes while enabled are ignored so a running calibration never sees a change
      if (index == cal_ctrl_pkg::IDX_MODE_CONFIG && !calEnable_reg[0]) modeConfig_reg <= pwdata[7:0]; // RQ14
      if (index == cal_ctrl_pkg::IDX_PIN_CONFIG) pinConfig_reg <= pwdata[7:0];
      if (index == cal_ctrl_pkg::IDX_SOFT_TRIG) softTrig_reg <= pwdata[7:0];
      if (index == cal_ctrl_pkg::IDX_IRQ_MASK) irqMask_reg <= pwdata[1:0];
    end
  end

  always_comb begin
    prdata = 32'h0;
    if (psel && !pwrite) begin
      unique case (index)
        cal_ctrl_pkg::IDX_CAL_ENABLE: prdata = {24'h0, calEnable_reg};
        cal_ctrl_pkg::IDX_MODE_CONFIG: prdata = {24'h0, modeConfig_reg};
        cal_ctrl_pkg::IDX_STATUS: prdata = {30'h0, bgStopped_reg, fgComplete_reg}; // RQ16
        cal_ctrl_pkg::IDX_PIN_CONFIG: prdata = {24'h0, pinConfig_reg};
        cal_ctrl_pkg::IDX_SOFT_TRIG: prdata = {24'h0, softTrig_reg};
        cal_ctrl_pkg::IDX_IRQ_STATUS: prdata = {30'h0, irqStatus_reg};
        cal_ctrl_pkg::IDX_IRQ_MASK: prdata = {30'h0, irqMask_reg};
        default: prdata = 32'h0;
      endcase
    end
  end

  // trigger routing
  assign calTrigger = pinConfig_reg[cal_ctrl_pkg::BIT_TRIG_SOURCE] ? trigSync // RQ12
    : softTrig_reg[0]; // RQ11
  assign calRun = calEnable_reg[0]; // RQ15

  // offset modes gated by their parent modes, offset filter by the enable only
  assign offsetFilterActive = calRun && modeConfig_reg[cal_ctrl_pkg::BIT_OFS_FILTER]; // RQ1
  assign backgroundOffsetActive = (state_reg == cal_ctrl_pkg::ST_BG) &&
    modeConfig_reg[cal_ctrl_pkg::BIT_BG_OFFSET] && modeConfig_reg[cal_ctrl_pkg::BIT_BG_ENABLE]; // RQ2
  assign foregroundOffsetActive = (state_reg == cal_ctrl_pkg::ST_FG) &&
    modeConfig_reg[cal_ctrl_pkg::BIT_FG_OFFSET] && modeConfig_reg[cal_ctrl_pkg::BIT_FG_SELECT]; // RQ3
  assign clearCalValues = (state_reg == cal_ctrl_pkg::ST_CLEAR);

  // calibration sequencer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg <= cal_ctrl_pkg::ST_IDLE;
      cnt_reg <= 8'h0;
    end else if (!calRun) begin
      state_reg <= cal_ctrl_pkg::ST_IDLE; // RQ15
      cnt_reg <= 8'h0;
    end else begin
      unique case (state_reg)
        cal_ctrl_pkg::ST_IDLE: begin
          if (calTrigger) begin
            state_reg <= cal_ctrl_pkg::ST_CLEAR;
            cnt_reg <= 8'(cal_ctrl_pkg::CLEAR_CYC - 1);
          end
        end
        cal_ctrl_pkg::ST_CLEAR: begin
          if (cnt_reg != 8'h0) begin
            cnt_reg <= cnt_reg - 8'h1;
          end else if (modeConfig_reg[cal_ctrl_pkg::BIT_FG_SELECT]) begin
            state_reg <= cal_ctrl_pkg::ST_FG; // RQ5
            cnt_reg <= 8'(cal_ctrl_pkg::FG_CAL_CYC - 1);
          end else if (modeConfig_reg[cal_ctrl_pkg::BIT_BG_ENABLE]) begin
            state_reg <= cal_ctrl_pkg::ST_BG; // RQ6
          end else begin
            state_reg <= cal_ctrl_pkg::ST_STOPPED; // RQ6
          end
        end
        cal_ctrl_pkg::ST_FG: begin
          if (cnt_reg != 8'h0) begin
            cnt_reg <= cnt_reg - 8'h1;
          end else if (modeConfig_reg[cal_ctrl_pkg::BIT_BG_ENABLE]) begin
            state_reg <= cal_ctrl_pkg::ST_BG; // RQ4
          end else begin
            state_reg <= cal_ctrl_pkg::ST_STOPPED; // RQ8
          end
        end
        cal_ctrl_pkg::ST_BG: begin
          // trigger low asks background calibration to halt at its phase
          if (!calTrigger) state_reg <= cal_ctrl_pkg::ST_STOPPED;
        end
        cal_ctrl_pkg::ST_STOPPED: begin
          if (calTrigger && modeConfig_reg[cal_ctrl_pkg::BIT_BG_ENABLE]) state_reg <= cal_ctrl_pkg::ST_BG;
        end
        default: state_reg <= cal_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // status flags
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fgComplete_reg <= 1'b0;
      bgStopped_reg <= 1'b0;
    end else if (!calRun) begin
      fgComplete_reg <= 1'b0;
      bgStopped_reg <= 1'b0;
    end else begin
      if (state_reg == cal_ctrl_pkg::ST_FG && cnt_reg == 8'h0) fgComplete_reg <= 1'b1; // RQ9
      if (state_reg == cal_ctrl_pkg::ST_CLEAR) fgComplete_reg <= 1'b0;
      bgStopped_reg <= (state_reg == cal_ctrl_pkg::ST_STOPPED); // RQ7
    end
  end

  // status pin, registered
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      statusPin_reg <= 1'b0;
    end else begin
      unique case (pinConfig_reg[cal_ctrl_pkg::BIT_STAT_SEL_LO +: 2])
        cal_ctrl_pkg::SEL_FG_COMPLETE: statusPin_reg <= fgComplete_reg; // RQ10
        cal_ctrl_pkg::SEL_ALARM: statusPin_reg <= alarmSync; // RQ10
        cal_ctrl_pkg::SEL_LOW: statusPin_reg <= 1'b0; // RQ10
        default: statusPin_reg <= 1'b0;
      endcase
    end
  end
  assign statusOutputPin = statusPin_reg;

  // sticky interrupt status, set wins over write-one-clear
  assign irqEvent = {bgStopped_reg == 1'b0 && state_reg == cal_ctrl_pkg::ST_STOPPED,
    state_reg == cal_ctrl_pkg::ST_FG && cnt_reg == 8'h0 && calRun};
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irqStatus_reg <= 2'h0;
    end else begin
      irqStatus_reg <= (irqStatus_reg & ~((wrEn && index == cal_ctrl_pkg::IDX_IRQ_STATUS) ? pwdata[1:0] : 2'h0))
        | irqEvent;
    end
  end
  assign irq = |(irqStatus_reg & irqMask_reg);

  // assertions
  property p_foreground_complete;
    @(posedge clk_sys) disable iff (!resetn)
      (calRun && state_reg == cal_ctrl_pkg::ST_FG && cnt_reg == 8'h0 && $past(calRun)) ##1 calRun |-> fgComplete_reg;
  endproperty
  a_foreground_complete: assert property (p_foreground_complete) else $error("foreground complete not set"); // RQ9

  sequence s_fg_finish_nobg;
    state_reg == cal_ctrl_pkg::ST_FG && cnt_reg == 8'h0 && calRun && !modeConfig_reg[cal_ctrl_pkg::BIT_BG_ENABLE];
  endsequence
  property p_stop_nobg;
    @(posedge clk_sys) disable iff (!resetn)
      s_fg_finish_nobg ##1 calRun [*2] |-> bgStopped_reg;
  endproperty
  a_stop_nobg: assert property (p_stop_nobg) else $error("stopped not set after foreground"); // RQ8

  property p_stopped_follows;
    @(posedge clk_sys) disable iff (!resetn)
      calRun && $past(calRun) |-> bgStopped_reg == ($past(state_reg) == cal_ctrl_pkg::ST_STOPPED);
  endproperty
  a_stopped_follows: assert property (p_stopped_follows) else $error("stopped flag wrong"); // RQ7

  property p_hold_reset;
    @(posedge clk_sys) disable iff (!resetn)
      !calRun |=> state_reg == cal_ctrl_pkg::ST_IDLE && !fgComplete_reg;
  endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("calibration not held in reset"); // RQ15

  property p_skip_fg;
    @(posedge clk_sys) disable iff (!resetn)
      state_reg == cal_ctrl_pkg::ST_CLEAR && !modeConfig_reg[cal_ctrl_pkg::BIT_FG_SELECT] && calRun
        |=> state_reg != cal_ctrl_pkg::ST_FG;
  endproperty
  a_skip_fg: assert property (p_skip_fg) else $error("foreground ran while deselected"); // RQ6

  property p_bg_only_enabled;
    @(posedge clk_sys) disable iff (!resetn)
      state_reg == cal_ctrl_pkg::ST_BG |-> modeConfig_reg[cal_ctrl_pkg::BIT_BG_ENABLE];
  endproperty
  a_bg_only_enabled: assert property (p_bg_only_enabled) else $error("background ran while disabled"); // RQ4

  property p_filter;
    @(posedge clk_sys) disable iff (!resetn)
      offsetFilterActive |-> modeConfig_reg[cal_ctrl_pkg::BIT_OFS_FILTER];
  endproperty
  a_filter: assert property (p_filter) else $error("filter without enable"); // RQ1

  property p_pin_low;
    @(posedge clk_sys) disable iff (!resetn)
      pinConfig_reg[2:1] == cal_ctrl_pkg::SEL_LOW |=> !statusOutputPin;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("status pin not low"); // RQ10

  property p_trig_pin;
    @(posedge clk_sys) disable iff (!resetn)
      pinConfig_reg[0] |-> calTrigger == trigSync;
  endproperty
  a_trig_pin: assert property (p_trig_pin) else $error("pin trigger not routed"); // RQ12

  property p_trig_soft;
    @(posedge clk_sys) disable iff (!resetn)
      !pinConfig_reg[cal_ctrl_pkg::BIT_TRIG_SOURCE] |-> calTrigger == softTrig_reg[0];
  endproperty
  a_trig_soft: assert property (p_trig_soft) else $error("software trigger not routed"); // RQ11

  sequence s_cal_start;
    calRun && state_reg == cal_ctrl_pkg::ST_IDLE && calTrigger;
  endsequence
  sequence s_clear_window;
    s_cal_start ##1 calRun [*8];
  endsequence
  property p_clear_span;
    @(posedge clk_sys) disable iff (!resetn)
      s_clear_window |-> clearCalValues && $past(clearCalValues, 7);
  endproperty
  a_clear_span: assert property (p_clear_span) else $error("clear span too short"); // RQ5

  property p_after_clear;
    @(posedge clk_sys) disable iff (!resetn)
      s_clear_window ##1 calRun |-> !clearCalValues &&
        ((state_reg == cal_ctrl_pkg::ST_FG) == modeConfig_reg[cal_ctrl_pkg::BIT_FG_SELECT]);
  endproperty
  a_after_clear: assert property (p_after_clear) else $error("foreground choice after clear wrong"); // RQ6

  property p_resume;
    @(posedge clk_sys) disable iff (!resetn)
      state_reg == cal_ctrl_pkg::ST_BG && $past(state_reg) == cal_ctrl_pkg::ST_STOPPED && calRun |=> !bgStopped_reg;
  endproperty
  a_resume: assert property (p_resume) else $error("stopped flag kept after resume"); // RQ7

  property p_status_zero;
    @(posedge clk_sys) disable iff (!resetn)
      psel && !pwrite && index == cal_ctrl_pkg::IDX_STATUS |-> prdata[31:2] == 30'h0;
  endproperty
  a_status_zero: assert property (p_status_zero) else $error("reserved status bits not zero"); // RQ16

  // a clear written in the same cycle as an event must not lose the event
  property p_irq_set_wins;
    @(posedge clk_sys) disable iff (!resetn)
      irqEvent != 2'h0 |=> (irqStatus_reg & $past(irqEvent)) == $past(irqEvent);
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins) else $error("interrupt event lost");
endmodule // adc_calibration_control

// ---- verif/cal_host_model.sv ----
// host-side model: drives the trigger and alarm pins and samples the status pin
`timescale 1ns/10ps
module cal_host_model (
  input wire logic clk_sys,
  input wire logic trigReq,
  input wire logic alarmReq,
  input wire logic statusOutputPin,
  output logic externalTriggerInput,
  output logic alarmFlag,
  output logic pinSeen
);
  initial begin
    externalTriggerInput = 1'b1;
    alarmFlag = 1'b0;
    pinSeen = 1'b0;
  end
  // pins move just after each clk_sys rising edge, in step with the block's clock, and still pass through its synchroniser
  always @(posedge clk_sys) begin
    externalTriggerInput <= trigReq;
    alarmFlag <= alarmReq;
    pinSeen <= statusOutputPin;
  end
endmodule // cal_host_model

// ---- verif/adc_calibration_control_test.sv ----
// self-checking bench for the calibration control block
`timescale 1ns/10ps
module adc_calibration_control_test;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, externalTriggerInput, alarmFlag, statusOutputPin, offsetFilterActive;
  logic foregroundOffsetActive, backgroundOffsetActive, clearCalValues, calTrigger, irq, pinSeen;
  logic trigReq = 1'b1;
  logic alarmReq = 1'b0;
  int failures = 0;
  int n_compared = 0;
  int clearCycles = 0;
  int fgOfsCycles = 0;
  logic [31:0] d;
  logic e;
  int c0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (clearCalValues === 1'b1) clearCycles <= clearCycles + 1;
    if (foregroundOffsetActive === 1'b1) fgOfsCycles <= fgOfsCycles + 1;
  end
  adc_calibration_control i_adc_calibration_control (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .externalTriggerInput(externalTriggerInput), .alarmFlag(alarmFlag),
    .statusOutputPin(statusOutputPin), .offsetFilterActive(offsetFilterActive),
    .foregroundOffsetActive(foregroundOffsetActive), .backgroundOffsetActive(backgroundOffsetActive),
    .clearCalValues(clearCalValues), .calTrigger(calTrigger), .irq(irq));
  cal_host_model i_cal_host_model (.clk_sys(clk_sys), .trigReq(trigReq), .alarmReq(alarmReq),
    .statusOutputPin(statusOutputPin), .externalTriggerInput(externalTriggerInput), .alarmFlag(alarmFlag),
    .pinSeen(pinSeen));
  task wrap_up;
    $display("compared %0d, failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask
  // one apb transfer; the request is held until pready is seen at a rising edge
  task apb(input logic [9:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    // no cycle budget here: a slave that never answers is caught by the watchdog
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the write land before a caller looks at what it changed
    @(negedge clk_sys);
  endtask
  task poll(input logic [9:0] idx, input logic [31:0] exp, input string msg);
    int n;
    n = 0;
    do begin
      apb(idx, 1'b0, 32'h0);
      n++;
    end while (d !== exp && n < 300);
    chk(d, exp, msg);
  endtask
  task settle;
    repeat (6) @(posedge clk_sys);
  endtask
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    chk(calTrigger, 1'b1, "trigger after reset");
    apb(cal_ctrl_pkg::IDX_CAL_ENABLE, 1'b0, 32'h0);
    chk(d, 32'h01, "enable reset");
    apb(cal_ctrl_pkg::IDX_MODE_CONFIG, 1'b0, 32'h0);
    chk(d, 32'h01, "mode reset");
    apb(cal_ctrl_pkg::IDX_PIN_CONFIG, 1'b0, 32'h0);
    chk(d, 32'h00, "pin config reset");
    apb(cal_ctrl_pkg::IDX_SOFT_TRIG, 1'b0, 32'h0);
    chk(d, 32'h01, "soft trigger reset");
    poll(cal_ctrl_pkg::IDX_STATUS, 32'h03, "first calibration status");
    chk(32'(clearCycles), 32'(cal_ctrl_pkg::CLEAR_CYC), "clear span");
    chk(32'(fgOfsCycles), 32'h0, "offset cal without its bit");
    // every selector, reserved one included, against both alarm levels
    for (int s = 0; s < 4; s++) begin
      for (int a = 0; a < 2; a++) begin
        alarmReq <= a[0];
        apb(cal_ctrl_pkg::IDX_PIN_CONFIG, 1'b1, {29'h0, 2'(s), 1'b0});
        settle();
        chk(pinSeen, (2'(s) == cal_ctrl_pkg::SEL_FG_COMPLETE) ? 1'b1 :
          (2'(s) == cal_ctrl_pkg::SEL_ALARM) ? a[0] : 1'b0, "status pin");
      end
    end
    apb(cal_ctrl_pkg::IDX_IRQ_STATUS, 1'b0, 32'h0);
    chk(d, 32'h03, "irq status");
    chk(irq, 1'b0, "irq masked");
    apb(cal_ctrl_pkg::IDX_IRQ_MASK, 1'b1, 32'h03);
    chk(irq, 1'b1, "irq unmasked");
    apb(cal_ctrl_pkg::IDX_IRQ_STATUS, 1'b1, 32'h01);
    chk(irq, 1'b1, "irq one bit left");
    apb(cal_ctrl_pkg::IDX_IRQ_STATUS, 1'b1, 32'h02);
    chk(irq, 1'b0, "irq cleared");
    // trigger source: software bit versus pin
    apb(cal_ctrl_pkg::IDX_PIN_CONFIG, 1'b1, 32'h00);
    apb(cal_ctrl_pkg::IDX_SOFT_TRIG, 1'b1, 32'h00);
    settle();
    chk(calTrigger, 1'b0, "soft trigger low, pin high");
    apb(cal_ctrl_pkg::IDX_PIN_CONFIG, 1'b1, 32'h01);
    settle();
    chk(calTrigger, 1'b1, "pin source high, soft low");
    trigReq <= 1'b0;
    apb(cal_ctrl_pkg::IDX_SOFT_TRIG, 1'b1, 32'h01);
    settle();
    chk(calTrigger, 1'b0, "pin source low, soft high");
    apb(cal_ctrl_pkg::IDX_PIN_CONFIG, 1'b1, 32'h00);
    settle();
    chk(calTrigger, 1'b1, "soft source, pin low");
    trigReq <= 1'b1;
    apb(cal_ctrl_pkg::IDX_MODE_CONFIG, 1'b1, 32'h1f);
    apb(cal_ctrl_pkg::IDX_MODE_CONFIG, 1'b0, 32'h0);
    chk(d, 32'h01, "mode write while enabled");
    apb(10'h3ff, 1'b0, 32'h0);
    chk({d[30:0], e}, 32'h1, "unmapped read");
    // skip foreground with filtering on; settings only change with enable low
    apb(cal_ctrl_pkg::IDX_CAL_ENABLE, 1'b1, 32'h00);
    apb(cal_ctrl_pkg::IDX_STATUS, 1'b0, 32'h0);
    chk(d, 32'h00, "status held in reset");
    apb(cal_ctrl_pkg::IDX_MODE_CONFIG, 1'b1, 32'h10);
    chk(offsetFilterActive, 1'b0, "filter while disabled");
    c0 = clearCycles;
    apb(cal_ctrl_pkg::IDX_CAL_ENABLE, 1'b1, 32'h01);
    chk(offsetFilterActive, 1'b1, "filter enabled");
    poll(cal_ctrl_pkg::IDX_STATUS, 32'h02, "foreground skipped");
    chk(32'(clearCycles - c0), 32'(cal_ctrl_pkg::CLEAR_CYC), "clear on skip");
    // foreground plus background, both offset modes
    apb(cal_ctrl_pkg::IDX_CAL_ENABLE, 1'b1, 32'h00);
    apb(cal_ctrl_pkg::IDX_MODE_CONFIG, 1'b1, 32'h0f);
    c0 = fgOfsCycles;
    apb(cal_ctrl_pkg::IDX_CAL_ENABLE, 1'b1, 32'h01);
    poll(cal_ctrl_pkg::IDX_STATUS, 32'h01, "background running");
    chk(backgroundOffsetActive, 1'b1, "background offset");
    chk(32'(fgOfsCycles - c0), 32'(cal_ctrl_pkg::FG_CAL_CYC), "foreground offset span");
    trigReq <= 1'b0;
    apb(cal_ctrl_pkg::IDX_PIN_CONFIG, 1'b1, 32'h01);
    poll(cal_ctrl_pkg::IDX_STATUS, 32'h03, "background halted");
    chk(backgroundOffsetActive, 1'b0, "halted offset off");
    trigReq <= 1'b1;
    poll(cal_ctrl_pkg::IDX_STATUS, 32'h01, "background resumed");
    wrap_up();
  end
endmodule // adc_calibration_control_test
